// [core/plldiv_pkg.sv]
// Purpose: Shared constants and carriers for the synthesizer divider programming block
// Assumes: AXI4-Lite register access, 32-bit data, word aligned
// Notes: All offsets are byte addresses

package plldiv_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CAL_TRIG = 8'h00;
  localparam logic [7:0] OFF_UPPER = 8'h04;
  localparam logic [7:0] OFF_DENOM = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_EFF = 8'h14;
  localparam logic [7:0] OFF_CALCNT = 8'h18;

  // Trigger word fields: numerator low 16, feedback divider low 12
  localparam int NUM_LO_POS = 0;
  localparam int NUM_LO_W = 16;
  localparam int NLO_POS = 16;
  localparam int N_LO_W = 12;
  // Upper word fields: numerator high 6, feedback high 6, reference 12
  localparam int NUM_HI_POS = 0;
  localparam int NUM_HI_W = 6;
  localparam int NHI_POS = 6;
  localparam int N_HI_W = 6;
  localparam int REF_POS = 12;
  localparam int REF_W = 12;
  localparam int FRAC_W = 22;
  localparam int N_W = 18;

  // Control bit positions
  localparam int CTRL_FRAC_POS = 0;
  localparam int CTRL_DBL_POS = 1;
  localparam int CTRL_INTVCO_POS = 2;
  localparam int CTRL_ORDER_POS = 4;

  // Reset values
  localparam logic [31:0] RST_CAL_TRIG = 32'h0000_0000;
  localparam logic [31:0] RST_UPPER = 32'h0000_1000;
  localparam logic [21:0] RST_DENOM = 22'h00_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0004;

  // Limits
  localparam logic [17:0] N_MIN_O1 = 18'h0_000C;
  localparam logic [17:0] N_MIN_O2 = 18'h0_000D;
  localparam logic [17:0] N_MIN_O3 = 18'h0_000F;
  localparam logic [17:0] N_MIN_O4 = 18'h0_0013;
  localparam logic [11:0] N_MAX_O4 = 12'hFF7;
  localparam logic [11:0] N_MAX_O3 = 12'hFFB;
  localparam logic [11:0] N_MAX_O2 = 12'hFFD;
  localparam logic [11:0] N_MAX_O1 = 12'hFFE;

  // Calibration pulse length in cycles
  localparam int CAL_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [3:0] CAL_CYCLES = 4'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PLLD_ORD_INT = 2'h0,
    PLLD_ORD_2 = 2'h1,
    PLLD_ORD_3 = 2'h2,
    PLLD_ORD_4 = 2'h3
  } plld_order_e;

  typedef enum logic [0:0] {
    PLLD_CAL_IDLE = 1'h0,
    PLLD_CAL_RUN = 1'h1
  } plld_cal_e;

  typedef struct packed {
    logic [11:0] ref_div;
    logic [17:0] fb_div;
    logic [21:0] numerator;
    logic [21:0] denominator;
    logic frac_mode;
    logic ref_bypass;
  } plld_div_s;

endpackage

// [core/plldiv_regs.sv]
// Purpose: Divider word bank with legality checks and calibration trigger
// Assumes: Single clock, AXI4-Lite slave, one outstanding read and write
// Notes: Illegal settings are flagged, never silently fixed

`timescale 1ns/1ps

// Contract
// - Every write to the trigger word starts a calibration when the internal oscillator is in use, same value or not.
// - The reference divider is 12 bits dividing by 1 to 4095, and zero is illegal unless the doubler is enabled.
// - With the doubler enabled the reference divider is bypassed.
// - In integer mode the feedback divider is the full 18 bits from two words, up to 262143.
// - In fractional mode only the low 12 feedback divider bits are used.
// - The 22-bit numerator spans two words and acts only in fractional mode.
// - The 22-bit denominator sits in one word and acts only in fractional mode.
module plldiv_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output plldiv_pkg::plld_div_s div_cfg,
  output logic cal_start,
  output logic cal_busy,
  output logic cfg_error
);
  import plldiv_pkg::*;

  logic [31:0] cal_trig_word;
  logic [31:0] upper_word;
  logic [21:0] fraction_denominator;
  logic [31:0] den_merged;
  logic [31:0] ctrl;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic [7:0] cal_count;
  logic [3:0] cal_timer;
  plld_cal_e cal_state;
  plld_div_s next_div;
  logic [17:0] n_full;
  logic [17:0] n_min;
  logic [11:0] n_max;
  logic [21:0] num_full;
  logic chk_ref;
  logic chk_nmin;
  logic chk_nmax;
  logic chk_num;
  logic [4:0] err_bits;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[7:2] <= OFF_CTRL[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming words
  assign den_merged = merge({10'h000, fraction_denominator}, w_data, w_strb);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cal_trig_word <= RST_CAL_TRIG;
      upper_word <= RST_UPPER;
      fraction_denominator <= RST_DENOM;
      ctrl <= RST_CTRL;
    end else if (do_write) begin
      case (aw_addr[7:2])
        OFF_CAL_TRIG[7:2]: cal_trig_word <= merge(cal_trig_word, w_data, w_strb);
        OFF_UPPER[7:2]: upper_word <= merge(upper_word, w_data, w_strb);
        OFF_DENOM[7:2]: fraction_denominator <= den_merged[21:0];
        OFF_CTRL[7:2]: ctrl <= merge(ctrl, w_data, w_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration: restarts on every trigger write with the internal oscillator, repeated values too
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cal_start <= 1'b0;
      cal_state <= PLLD_CAL_IDLE;
      cal_timer <= 4'h0;
      cal_busy <= 1'b0;
      cal_count <= 8'h00;
    end else begin
      cal_start <= 1'b0;
      if (do_write && aw_addr[7:2] == OFF_CAL_TRIG[7:2] && ctrl[CTRL_INTVCO_POS]) begin
        cal_start <= 1'b1;
        cal_state <= PLLD_CAL_RUN;
        cal_timer <= CAL_CYCLES;
        cal_busy <= 1'b1;
        cal_count <= cal_count + 8'h01;
      end else begin
        case (cal_state)
          PLLD_CAL_RUN: begin
            if (cal_timer == 4'h1) begin
              cal_state <= PLLD_CAL_IDLE;
              cal_busy <= 1'b0;
            end
            cal_timer <= cal_timer - 4'h1;
          end
          default: cal_state <= PLLD_CAL_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective divider settings
  assign n_full = {upper_word[NHI_POS +: N_HI_W], cal_trig_word[NLO_POS +: N_LO_W]};
  assign num_full = {upper_word[NUM_HI_POS +: NUM_HI_W], cal_trig_word[NUM_LO_POS +: NUM_LO_W]};

  always_comb begin
    next_div.ref_div = upper_word[REF_POS +: REF_W];
    next_div.ref_bypass = ctrl[CTRL_DBL_POS];
    next_div.frac_mode = ctrl[CTRL_FRAC_POS];
    if (ctrl[CTRL_FRAC_POS]) begin
      next_div.fb_div = {6'h00, n_full[11:0]};
      next_div.numerator = num_full;
      next_div.denominator = fraction_denominator;
    end else begin
      next_div.fb_div = n_full;
      next_div.numerator = 22'h00_0000;
      next_div.denominator = 22'h00_0000;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cfg <= '0;
    end else begin
      div_cfg <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Legality checks; order field only matters in fractional mode
  always_comb begin
    n_min = N_MIN_O1;
    n_max = N_MAX_O1;
    if (ctrl[CTRL_FRAC_POS]) begin
      case (plld_order_e'(ctrl[CTRL_ORDER_POS +: 2]))
        PLLD_ORD_2: begin n_min = N_MIN_O2; n_max = N_MAX_O2; end
        PLLD_ORD_3: begin n_min = N_MIN_O3; n_max = N_MAX_O3; end
        PLLD_ORD_4: begin n_min = N_MIN_O4; n_max = N_MAX_O4; end
        default: begin n_min = N_MIN_O1; n_max = N_MAX_O1; end
      endcase
    end
  end

  assign chk_ref = (upper_word[REF_POS +: REF_W] == 12'h000) && !ctrl[CTRL_DBL_POS];
  assign chk_nmin = next_div.fb_div < n_min;
  assign chk_nmax = ctrl[CTRL_FRAC_POS] && (n_full[11:0] > n_max);
  assign chk_num = ctrl[CTRL_FRAC_POS] && (num_full > fraction_denominator);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_bits <= 5'h00;
      cfg_error <= 1'b0;
    end else begin
      err_bits <= {1'b0, chk_num, chk_nmax, chk_nmin, chk_ref};
      cfg_error <= chk_ref | chk_nmin | chk_nmax | chk_num;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr[7:2])
          OFF_CAL_TRIG[7:2]: s_axi_rdata <= cal_trig_word;
          OFF_UPPER[7:2]: s_axi_rdata <= upper_word;
          OFF_DENOM[7:2]: s_axi_rdata <= {10'h000, fraction_denominator};
          OFF_CTRL[7:2]: s_axi_rdata <= ctrl;
          OFF_STATUS[7:2]: s_axi_rdata <= {26'h000_0000, cal_busy, err_bits};
          OFF_EFF[7:2]: s_axi_rdata <= {14'h0000, div_cfg.fb_div};
          OFF_CALCNT[7:2]: s_axi_rdata <= {24'h00_0000, cal_count};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cal_on_write;
    @(posedge clock) disable iff (!rst_b)
      (do_write && aw_addr[7:2] == 6'h00 && ctrl[CTRL_INTVCO_POS]) |=> cal_start && cal_busy;
  endproperty
  a_cal_on_write: assert property (p_cal_on_write) else $error("calibration not started");

  property p_no_cal_ext;
    @(posedge clock) disable iff (!rst_b)
      (do_write && !ctrl[CTRL_INTVCO_POS]) |=> !cal_start;
  endproperty
  a_no_cal_ext: assert property (p_no_cal_ext) else $error("calibration with external oscillator");

  property p_ref_zero;
    @(posedge clock) disable iff (!rst_b)
      (upper_word[23:12] == 12'h000 && !ctrl[1]) |=> err_bits[0];
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("zero reference divider not flagged");

  property p_bypass;
    @(posedge clock) disable iff (!rst_b)
      ctrl[1] |=> div_cfg.ref_bypass && !err_bits[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("doubler bypass wrong");

  property p_int_full;
    @(posedge clock) disable iff (!rst_b)
      !ctrl[0] |=> div_cfg.fb_div == $past(n_full);
  endproperty
  a_int_full: assert property (p_int_full) else $error("integer divider wrong");

  property p_frac_low;
    @(posedge clock) disable iff (!rst_b)
      ctrl[0] |=> div_cfg.fb_div[17:12] == 6'h00 && div_cfg.numerator == $past(num_full);
  endproperty
  a_frac_low: assert property (p_frac_low) else $error("fractional divider wrong");

  property p_num_int;
    @(posedge clock) disable iff (!rst_b)
      !ctrl[0] |=> div_cfg.numerator == 22'h00_0000 && div_cfg.denominator == 22'h00_0000;
  endproperty
  a_num_int: assert property (p_num_int) else $error("fraction active in integer mode");

  property p_nmin;
    @(posedge clock) disable iff (!rst_b)
      (ctrl[0] && ctrl[5:4] == 2'h3 && n_full[11:0] < 12'h013) |=> err_bits[1] && cfg_error;
  endproperty
  a_nmin: assert property (p_nmin) else $error("low divider not flagged");

  property p_cal_len;
    @(posedge clock) disable iff (!rst_b)
      $rose(cal_busy) |-> cal_busy [*8];
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration too short");

endmodule

// [tb/plldiv_host.sv]
// Purpose: Host model that loads divider words over AXI4-Lite
// Assumes: One write and one read at a time
// Notes: Waits on the answer, never on a cycle count
`timescale 1ns/1ps
module plldiv_host (
  input wire logic clock,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
  end
  ////////////////////////////////////////////////////////////
  // Numerator never above denominator, so the ratio stays sane
  function automatic logic [21:0] fix_num(input logic [21:0] n, input logic [21:0] d);
    return (n > d) ? d : n;
  endfunction
  // Bench keeps ref 1 and legal N outside the reference and limit tests, so rates stay in range
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the divider word bank
// Assumes: Reads checked from a queue of expected answers
// Notes: Outputs are given three cycles to settle after a write
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import plldiv_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cal_start, cal_busy, cfg_error;
  plld_div_s div_cfg;
  int miscompares = 0;
  int tests_run = 0;
  int cal_seen = 0;
  int c;
  logic [33:0] expq[$];
  logic [33:0] exp_rd;
  logic [31:0] lfsr = 32'h0000_094d;
  logic [21:0] den, num;
  logic [11:0] n;
  // Packed as ctrl byte, error nibble, N
  logic [23:0] lim [16] = '{24'h04_100B, 24'h04_000C, 24'h15_100C, 24'h15_000D, 24'h25_100E, 24'h25_000F,
    24'h25_0FFB, 24'h25_1FFC, 24'h35_1012, 24'h35_0013, 24'h35_0FF7, 24'h35_1FF8, 24'h15_0FFD,
    24'h15_1FFE, 24'h05_0FFE, 24'h05_1FFF};
  plldiv_regs plldiv_regs_i (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .div_cfg, .cal_start, .cal_busy, .cfg_error);
  plldiv_host plldiv_host_i (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        exp_rd = expq.pop_front();
        `CHK({s_axi_rresp, s_axi_rdata}, exp_rd)
      end
    end
    if (cal_start === 1'b1) cal_seen++;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    plldiv_host_i.wr(a, d, resp);
    `CHK(resp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    plldiv_host_i.rd(a);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(OFF_UPPER, {RESP_OKAY, RST_UPPER});
    rd(OFF_CTRL, {RESP_OKAY, RST_CTRL});
    rd(OFF_CAL_TRIG, {RESP_OKAY, RST_CAL_TRIG});
    $display("reset test done");
    c = cal_seen;
    wr(OFF_CAL_TRIG, 32'h0013_0000, RESP_OKAY);
    wr(OFF_CAL_TRIG, 32'h0013_0000, RESP_OKAY);
    settle();
    `CHK(cal_seen - c, 2)
    `CHK(cal_busy, 1'b1)
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CAL_TRIG, 32'h0013_0000, RESP_OKAY);
    settle();
    `CHK(cal_seen - c, 2)
    $display("calibration test done");
    wr(OFF_CTRL, 32'h0000_0004, RESP_OKAY);
    wr(OFF_UPPER, 32'h0000_1FC0, RESP_OKAY);
    wr(OFF_CAL_TRIG, 32'h0FFF_0000, RESP_OKAY);
    settle();
    `CHK(div_cfg.fb_div, 18'h3_FFFF)
    `CHK(div_cfg.frac_mode, 1'b0)
    `CHK(div_cfg.ref_div, 12'h001)
    rd(OFF_EFF, {RESP_OKAY, 32'h0003_FFFF});
    $display("integer test done");
    // High N bits stay set to prove they are ignored
    wr(OFF_CTRL, 32'h0000_0035, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      den = 22'(rnd());
      num = plldiv_host_i.fix_num(22'(rnd()), den);
      n = 12'(rnd() % 4000) + 12'h013;
      wr(OFF_DENOM, {10'h000, den}, RESP_OKAY);
      wr(OFF_UPPER, {8'h00, 12'h001, 6'h3F, num[21:16]}, RESP_OKAY);
      wr(OFF_CAL_TRIG, {4'h0, n, num[15:0]}, RESP_OKAY);
      settle();
      `CHK(div_cfg.fb_div, {6'h00, n})
      `CHK(div_cfg.numerator, num)
      `CHK(div_cfg.denominator, den)
      `CHK(div_cfg.frac_mode, 1'b1)
      `CHK(cfg_error, 1'b0)
    end
    $display("fractional test done");
    wr(OFF_CTRL, 32'h0000_0004, RESP_OKAY);
    wr(OFF_UPPER, 32'h0000_0000, RESP_OKAY);
    settle();
    `CHK(cfg_error, 1'b1)
    wr(OFF_CTRL, 32'h0000_0006, RESP_OKAY);
    settle();
    `CHK(div_cfg.ref_bypass, 1'b1)
    `CHK(cfg_error, 1'b0)
    $display("reference test done");
    wr(OFF_UPPER, 32'h0000_1000, RESP_OKAY);
    foreach (lim[i]) begin
      wr(OFF_CTRL, {24'h00_0000, lim[i][23:16]}, RESP_OKAY);
      wr(OFF_CAL_TRIG, {4'h0, lim[i][11:0], 16'h0000}, RESP_OKAY);
      settle();
      `CHK(cfg_error, lim[i][12])
    end
    wr(OFF_DENOM, 32'h0000_0010, RESP_OKAY);
    wr(OFF_CAL_TRIG, 32'h0100_0011, RESP_OKAY);
    settle();
    `CHK(cfg_error, 1'b1)
    $display("limit test done");
    wr(OFF_STATUS, 32'h0000_0001, RESP_SLVERR);
    wr(8'h40, 32'h0000_0000, RESP_SLVERR);
    rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
    rd(OFF_DENOM, {RESP_OKAY, 32'h0000_0010});
    rd(OFF_CALCNT, {RESP_OKAY, 32'h0000_0018});
    $display("bus test done");
    settle();
    tally_and_finish();
  end
endmodule
